// *** hw/pdsc_port_drive.sv ***
// Purpose: eight-pin port with per-pin pad drive-strength selection
// Assumes: Avalon-MM slave, byte addressed, 32-bit words, waitrequest
// Notes:   every access answers at the second edge after it is raised
//
// Operation
// - one drive-select bit per pin, bits 7 down to 0, each for its own pin.
// - a set bit requests reduced drive, a clear bit requests full drive.
// - a drive-select bit has no effect while its pin is an input.
// - the select applies whether port logic or a peripheral drives the pin.
// - the select register is read/write anytime and resets to all zero.
// - data and read-back settle within two clocks of a direction change.
`timescale 1ns/1ns
module pdsc_port_drive #(
    parameter int PINS = pdsc_pkg::PDSC_PINS
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            nrst,
    // avalon-mm slave
    input  wire logic [pdsc_pkg::PDSC_ADDR_W-1:0] avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [pdsc_pkg::PDSC_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                      avs_byteenable,
    output logic      [pdsc_pkg::PDSC_DATA_W-1:0] avs_readdata,
    output logic                                 avs_waitrequest,
    output logic      [1:0]                      avs_response,
    // routed peripheral functions
    input  wire logic [PINS-1:0]                 periph_enable,
    input  wire logic [PINS-1:0]                 periph_out,
    // pad ring
    input  wire logic [PINS-1:0]                 pad_in,
    output logic      [PINS-1:0]                 pad_out,
    output logic      [PINS-1:0]                 pad_oe_n,
    output logic      [PINS-1:0]                 pad_reduced_drive
);
    import pdsc_pkg::*;

    // bus sequencer state
    pdsc_bus_t                 bus_state_ff;
    pdsc_bus_t                 nxt_bus_state;
    logic [PDSC_DATA_W-1:0]    rdata_ff;
    logic [PDSC_DATA_W-1:0]    nxt_rdata;
    logic [1:0]                resp_ff;
    logic [1:0]                nxt_resp;

    // software-visible port state
    logic [PINS-1:0]           pin_data_value_ff;
    logic [PINS-1:0]           nxt_pin_data_value;
    logic [PINS-1:0]           pin_direction_control_ff;
    logic [PINS-1:0]           nxt_pin_direction_control;
    logic [PINS-1:0]           pad_drive_select_ff;
    logic [PINS-1:0]           nxt_pad_drive_select;

    // decode and derived terms
    logic                      req;
    logic                      wr_commit;
    logic                      low_lane;
    logic                      hit_data;
    logic                      hit_readback;
    logic                      hit_dir;
    logic                      hit_drive;
    logic                      hit_effect;
    logic                      hit_any;
    logic [PINS-1:0]           pin_input_readback;
    logic [PINS-1:0]           pin_is_output;
    logic [PINS-1:0]           port_view;

    // -----------------------------------------------------------------
    // input synchronisation; the two stages are why read-back can lag
    // a direction change by up to two clocks
    // -----------------------------------------------------------------
    pdsc_sync #(
        .WIDTH (PINS)
    ) u_in_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     (pad_in),
        .q     (pin_input_readback)
    );

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    always_comb begin
        req          = avs_read | avs_write;
        low_lane     = avs_byteenable[0];
        hit_data     = (avs_address == PDSC_ADDR_DATA);
        hit_readback = (avs_address == PDSC_ADDR_READBACK);
        hit_dir      = (avs_address == PDSC_ADDR_DIR);
        hit_drive    = (avs_address == PDSC_ADDR_DRIVE);
        hit_effect   = (avs_address == PDSC_ADDR_EFFECT);
        hit_any      = hit_data | hit_readback | hit_dir | hit_drive
                     | hit_effect;
    end

    // a write lands only at the edge where waitrequest is seen low
    always_comb begin
        wr_commit = avs_write & (bus_state_ff == PDSC_BUS_ACK);
    end

    // -----------------------------------------------------------------
    // bus answer sequencer: one wait cycle gives time to register the
    // read data, so readdata never comes straight off the address mux
    // -----------------------------------------------------------------
    always_comb begin
        nxt_bus_state = bus_state_ff;
        unique case (bus_state_ff)
            PDSC_BUS_IDLE: begin
                if (req) begin
                    nxt_bus_state = PDSC_BUS_ACK;
                end
            end
            PDSC_BUS_ACK: begin
                nxt_bus_state = PDSC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus_state_ff <= PDSC_BUS_IDLE;
        end else begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    // waitrequest drops for exactly the answering cycle
    assign avs_waitrequest = req & (bus_state_ff != PDSC_BUS_ACK);

    // -----------------------------------------------------------------
    // pin view for the data register: pins with their direction bit set show
    // what the port holds, all others show the synchronised pad level
    // -----------------------------------------------------------------
    always_comb begin
        port_view = (pin_direction_control_ff & pin_data_value_ff)
                  | (~pin_direction_control_ff & pin_input_readback);
    end

    // -----------------------------------------------------------------
    // read data and response, captured while the request waits
    // -----------------------------------------------------------------
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_resp  = resp_ff;
        if (req && bus_state_ff == PDSC_BUS_IDLE) begin
            nxt_rdata = '0;
            nxt_resp  = hit_any ? PDSC_RESP_OKAY : PDSC_RESP_DECERR;
            if (avs_read) begin
                if (hit_data) begin
                    nxt_rdata[PINS-1:0] = port_view;
                end
                if (hit_readback) begin
                    nxt_rdata[PINS-1:0] = pin_input_readback;
                end
                if (hit_dir) begin
                    nxt_rdata[PINS-1:0] = pin_direction_control_ff;
                end
                if (hit_drive) begin
                    nxt_rdata[PINS-1:0] = pad_drive_select_ff;
                end
                if (hit_effect) begin
                    nxt_rdata[PINS-1:0] = pad_drive_select_ff
                                        & pin_is_output;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= '0;
            resp_ff  <= PDSC_RESP_OKAY;
        end else begin
            rdata_ff <= nxt_rdata;
            resp_ff  <= nxt_resp;
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_response = resp_ff;

    // -----------------------------------------------------------------
    // register writes; only byte lane 0 carries the eight pin bits,
    // upper lanes are ignored since those bits read as zero
    // -----------------------------------------------------------------
    always_comb begin
        nxt_pin_data_value        = pin_data_value_ff;
        nxt_pin_direction_control = pin_direction_control_ff;
        nxt_pad_drive_select      = pad_drive_select_ff;
        if (wr_commit && low_lane) begin
            if (hit_data) begin
                nxt_pin_data_value = avs_writedata[PINS-1:0];
            end
            if (hit_dir) begin
                nxt_pin_direction_control = avs_writedata[PINS-1:0];
            end
            if (hit_drive) begin
                nxt_pad_drive_select = avs_writedata[PINS-1:0];
            end
        end
    end

    // the select is writable at any time and clears to full drive
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_data_value_ff        <= PDSC_RST_DATA[PINS-1:0];
            pin_direction_control_ff <= PDSC_RST_DIR[PINS-1:0];
            pad_drive_select_ff      <= PDSC_RST_DRIVE[PINS-1:0];
        end else begin
            pin_data_value_ff        <= nxt_pin_data_value;
            pin_direction_control_ff <= nxt_pin_direction_control;
            pad_drive_select_ff      <= nxt_pad_drive_select;
        end
    end

    // -----------------------------------------------------------------
    // per-pin pad control
    // a pin drives when port direction or a routed peripheral says so;
    // the peripheral overrides the port data but not the drive select.
    // the select path is combinational from the flop so a write shows
    // at the pad on the very edge that completes it; the peripheral
    // terms are assumed to come from flops in their own blocks
    // -----------------------------------------------------------------
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_comb begin
            pin_is_output[i] = pin_direction_control_ff[i]
                             | periph_enable[i];
        end

        always_comb begin
            pad_out[i] = periph_enable[i] ? periph_out[i]
                                          : pin_data_value_ff[i];
            pad_oe_n[i] = ~pin_is_output[i];
        end

        // 1 = reduced, 0 = full; forced full while the pin is an
        // input so a stale select never reaches an undriven pad
        always_comb begin
            pad_reduced_drive[i] = pad_drive_select_ff[i]
                                 & pin_is_output[i];
        end
    end

endmodule : pdsc_port_drive

// *** hw/pdsc_pkg.sv ***
// Purpose: shared constants for the port pad drive-select block
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word
// Notes:   register indices are word numbers; byte address = 4 * index
package pdsc_pkg;

    // widths
    localparam int PDSC_PINS   = 8;
    localparam int PDSC_ADDR_W = 14;
    localparam int PDSC_DATA_W = 32;

    // register indices
    localparam logic [11:0] PDSC_IDX_DATA     = 12'h0240;
    localparam logic [11:0] PDSC_IDX_READBACK = 12'h0241;
    localparam logic [11:0] PDSC_IDX_DIR      = 12'h0242;
    localparam logic [11:0] PDSC_IDX_DRIVE    = 12'h0243;
    localparam logic [11:0] PDSC_IDX_EFFECT   = 12'h024F;

    // byte addresses derived from the indices
    localparam logic [PDSC_ADDR_W-1:0] PDSC_ADDR_DATA     =
        {PDSC_IDX_DATA, 2'b00};
    localparam logic [PDSC_ADDR_W-1:0] PDSC_ADDR_READBACK =
        {PDSC_IDX_READBACK, 2'b00};
    localparam logic [PDSC_ADDR_W-1:0] PDSC_ADDR_DIR      =
        {PDSC_IDX_DIR, 2'b00};
    localparam logic [PDSC_ADDR_W-1:0] PDSC_ADDR_DRIVE    =
        {PDSC_IDX_DRIVE, 2'b00};
    localparam logic [PDSC_ADDR_W-1:0] PDSC_ADDR_EFFECT   =
        {PDSC_IDX_EFFECT, 2'b00};

    // reset values
    localparam logic [7:0] PDSC_RST_DATA  = 8'h00;
    localparam logic [7:0] PDSC_RST_DIR   = 8'h00;
    localparam logic [7:0] PDSC_RST_DRIVE = 8'h00;

    // input synchroniser depth in bus clocks
    localparam int PDSC_SYNC_STAGES = 2;

    // avalon response codes
    localparam logic [1:0] PDSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PDSC_RESP_DECERR = 2'h3;

    // bus answer sequencer
    typedef enum logic [0:0] {
        PDSC_BUS_IDLE = 1'b0,
        PDSC_BUS_ACK  = 1'b1
    } pdsc_bus_t;

endpackage : pdsc_pkg

// *** hw/pdsc_sync.sv ***
// Purpose: two-flop level synchroniser for the pad input bits
// Assumes: inputs may change at any time relative to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module pdsc_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    import pdsc_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] q_ff;
    logic [WIDTH-1:0] nxt_q;

    // next values: stage one samples, stage two samples stage one
    always_comb begin
        nxt_meta = d;
        nxt_q    = meta_ff;
    end

    // registers; async reset loads constants only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= nxt_meta;
            q_ff    <= nxt_q;
        end
    end

    assign q = q_ff;

endmodule : pdsc_sync

// *** bench/pdsc_checker.sv ***
// Purpose: port assertions for the pad drive-select block
// Assumes: one clock domain, async active-low reset
// Notes:   a pin counts as an output while its pad_oe_n is low
`timescale 1ns/1ns
module pdsc_checker
    import pdsc_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic                              clock,
    input wire logic                              nrst,
    // avalon-mm slave
    input wire logic [pdsc_pkg::PDSC_ADDR_W-1:0] avs_address,
    input wire logic                              avs_read,
    input wire logic                              avs_write,
    input wire logic [pdsc_pkg::PDSC_DATA_W-1:0] avs_writedata,
    input wire logic [3:0]                        avs_byteenable,
    input wire logic [pdsc_pkg::PDSC_DATA_W-1:0] avs_readdata,
    input wire logic                              avs_waitrequest,
    input wire logic [1:0]                        avs_response,
    // pad ring
    input wire logic [PINS-1:0]                   pad_oe_n,
    input wire logic [PINS-1:0]                   pad_reduced_drive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // answer edge and decode, kept apart so the properties stay short
    logic done;
    logic drv_wr;
    logic mapped;
    assign done   = (avs_read | avs_write) & ~avs_waitrequest;
    assign drv_wr = done & avs_write & avs_byteenable[0]
                  & (avs_address == PDSC_ADDR_DRIVE);
    assign mapped = avs_address inside {PDSC_ADDR_DATA, PDSC_ADDR_READBACK,
                    PDSC_ADDR_DIR, PDSC_ADDR_DRIVE, PDSC_ADDR_EFFECT};
    gate_inputs_a: assert property (
        (pad_reduced_drive & pad_oe_n) == '0)
        else $error("reduced drive on an input pin");
    reset_full_a: assert property ($rose(nrst) |->
        pad_reduced_drive == '0) else $error("drive not full after reset");
    drive_write_a: assert property (drv_wr |=>
        pad_reduced_drive == ($past(avs_writedata[PINS-1:0]) & ~pad_oe_n))
        else $error("pad select does not follow the write");
    drive_hold_a: assert property (
        !$past(drv_wr) && $stable(pad_oe_n) |-> $stable(pad_reduced_drive))
        else $error("pad select moved without a write");
    wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("answer not after one wait");
    answer_once_a: assert property (done |=>
        avs_waitrequest || !(avs_read || avs_write))
        else $error("answer held past one cycle");
    unmapped_read_a: assert property (done && avs_read && !mapped |->
        avs_response == PDSC_RESP_DECERR && avs_readdata == '0)
        else $error("unmapped read not refused");
    mapped_okay_a: assert property (done && mapped |->
        avs_response == PDSC_RESP_OKAY) else $error("mapped access refused");
endmodule : pdsc_checker

bind pdsc_port_drive pdsc_checker #(.PINS(PINS)) i_chk (
    .clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pad_oe_n(pad_oe_n),
    .pad_reduced_drive(pad_reduced_drive));

// *** bench/pdsc_pad_model.sv ***
// Purpose: behavioural pad ring for the port pins
// Assumes: a released pin is held by the board at ext_level
// Notes:   drive strength does not change the logic level seen
`timescale 1ns/1ns
module pdsc_pad_model #(
    parameter int PINS = 8
) (
    // from the port
    input  wire logic [PINS-1:0] pad_out,
    input  wire logic [PINS-1:0] pad_oe_n,
    // board side
    input  wire logic [PINS-1:0] ext_level,
    output logic      [PINS-1:0] pad_in
);
    // a driven pin shows the port value, a released one the board level
    always_comb begin
        pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
    end
endmodule : pdsc_pad_model

// *** bench/pdsc_port_drive_tb.sv ***
// Purpose: self-checking bench for pdsc_port_drive
// Assumes: one wait cycle per access, reads checked by a monitor
// Notes:   random pins and select values from a fixed seed
`timescale 1ns/1ns
module pdsc_port_drive_tb;
    import pdsc_pkg::*;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [13:0] avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [7:0]  periph_enable = 8'h00;
    logic [7:0]  periph_out = 8'h00;
    logic [7:0]  ext_level = 8'h00;
    logic [7:0]  pad_in, pad_out, pad_oe_n, pad_reduced_drive;
    logic [7:0]  dir, drv, pe, dat, po, vw;
    logic [31:0] exp_d[$];
    logic [1:0]  exp_r[$];
    int          err_total = 0;
    int          tests_run = 0;
    always #4 clock = ~clock;
    pdsc_port_drive i_dut (.clock(clock), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .periph_enable(periph_enable), .periph_out(periph_out),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_reduced_drive(pad_reduced_drive));
    pdsc_pad_model i_pad (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .ext_level(ext_level), .pad_in(pad_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // request held until waitrequest is seen low; release is left to idle
    task automatic bus(input logic wr, input logic [13:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        logic wt;
        int   n;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        wt = 1'b1;
        for (n = 0; wt; n++) begin
            if (n > 20) begin
                err_total++;
                $display("CHECK FAILED %0t: bus hang", $time);
                end_of_test();
            end
            @(negedge clock);
            wt = (avs_waitrequest !== 1'b0);
            @(posedge clock);
        end
    endtask : bus
    task automatic rd(input logic [13:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        exp_d.push_back(e);
        exp_r.push_back(r);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd
    task automatic idle;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : idle
    // read answers are matched against the oldest expectation
    always @(negedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_d.size() == 0) begin
                // an answer that nobody asked for is a mismatch
                check(32'h0000_0001, 32'h0000_0000);
            end else begin
                check(avs_readdata, exp_d.pop_front());
                check({30'h0, avs_response},
                      {30'h0, exp_r.pop_front()});
            end
        end
    end
    initial begin
        void'($urandom(32'hf265));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        check({24'h0, pad_reduced_drive}, 32'h0);
        rd(PDSC_ADDR_DRIVE, 32'h0, PDSC_RESP_OKAY);
        // two corner sweeps, then random pins, back-to-back accesses
        for (int i = 0; i < 14; i++) begin
            drv = (i < 2) ? 8'hFF : 8'($urandom);
            dir = (i < 2) ? {8{i[0]}} : 8'($urandom);
            pe = (i < 2) ? 8'h00 : 8'($urandom);
            po = 8'($urandom);
            vw = drv & (dir | pe);
            periph_enable <= pe;
            periph_out <= po;
            bus(1'b1, PDSC_ADDR_DIR, {24'h0, dir}, 4'hF);
            bus(1'b1, PDSC_ADDR_DRIVE, {24'h0, drv}, 4'hF);
            rd(PDSC_ADDR_DRIVE, {24'h0, drv}, PDSC_RESP_OKAY);
            rd(PDSC_ADDR_DIR, {24'h0, dir}, PDSC_RESP_OKAY);
            rd(PDSC_ADDR_EFFECT, {24'h0, vw}, PDSC_RESP_OKAY);
            idle();
            @(negedge clock);
            check({24'h0, pad_reduced_drive}, {24'h0, vw});
            check({24'h0, pad_oe_n}, {24'h0, ~(dir | pe)});
            // the data register still holds its reset value here
            check({24'h0, pad_out & pe}, {24'h0, po & pe});
            check({24'h0, pad_out & ~pe}, {24'h0, PDSC_RST_DATA & ~pe});
            // back onto the rising edge before the next request
            @(posedge clock);
        end
        // an upper-lane write and an unmapped write leave the select alone
        bus(1'b1, PDSC_ADDR_DRIVE, ~{24'h0, drv}, 4'hE);
        bus(1'b1, 14'h0910, 32'h0000_00FF, 4'hF);
        rd(14'h0910, 32'h0, PDSC_RESP_DECERR);
        rd(PDSC_ADDR_DRIVE, {24'h0, drv}, PDSC_RESP_OKAY);
        // data view settles two clocks after a direction change
        periph_enable <= 8'h00;
        ext_level <= 8'h3C;
        dat = 8'($urandom);
        bus(1'b1, PDSC_ADDR_DATA, {24'h0, dat}, 4'hF);
        for (int i = 0; i < 2; i++) begin
            dir = i[0] ? 8'hF0 : 8'h0F;
            bus(1'b1, PDSC_ADDR_DIR, {24'h0, dir}, 4'hF);
            idle();
            repeat (2) @(posedge clock);
            vw = (dat & dir) | (8'h3C & ~dir);
            rd(PDSC_ADDR_DATA, {24'h0, vw}, PDSC_RESP_OKAY);
            rd(PDSC_ADDR_READBACK, {24'h0, vw}, PDSC_RESP_OKAY);
        end
        idle();
        // reset in mid-run returns the pins to full drive
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(PDSC_ADDR_DRIVE, 32'h0, PDSC_RESP_OKAY);
        idle();
        check({24'h0, pad_reduced_drive}, 32'h0);
        // every read that was asked for must have been answered
        check(32'(exp_d.size()), 32'h0);
        end_of_test();
    end
endmodule : pdsc_port_drive_tb
